// ==== hw/amc_ctrl.sv ====
// converter input, reference and result control with register port
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - noise-reduction or idle sleep with converter prepared starts conversion on core halt.
// - undisturbed sleep conversion raises interrupt that wakes the processor.
// - single-ended result is unsigned 10-bit code, 0x000 ground, 0x3FF near reference.
// - differential result saturates at zero when positive input not above negative.
// - differential result clamps at 0x3FF for full-scale difference or more.
// - reference select decodes supply, pin, internal open, internal with capacitor.
// - reference or channel change mid-conversion waits until conversion completes.
// - left-align clear gives right-aligned result, set gives left-aligned.
// - left-align change alters result presentation at once, even mid-conversion.
// - codes 0 to 10 route single-ended inputs 0 to 10, gain bypassed.
// - codes 01011 to 10101 select listed differential pairs and gains.
// - codes 10111 to 11101 select pairs 6-5, 8-9, 10-9 at listed gains.
// - codes 01101, 10001, 10110, 11011 short one input to both terminals, 20x.
// - code 11110 selects bandgap, 11111 selects ground.
// - selection follows writes while idle, locked in conversion, freed in last cycle.
// - low byte read blocks result updates until high byte read; irq still fires.
// - done flag sets on completion; requests irq with both enables set.

module amc_ctrl
  import amc_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        global_irq_enable,
  input  wire logic        sleep_adc_mode,
  input  wire logic        cpu_halted,
  input  wire logic        irq_ack,
  output logic             conv_irq,
  output logic             wake_request,
  output logic             core_enable,
  output logic             core_start,
  input  wire logic        core_done,
  input  wire logic        core_last_cycle,
  input  wire logic [11:0] core_raw,
  output logic      [3:0]  mux_pos_sel,
  output logic      [3:0]  mux_neg_sel,
  output logic             mux_diff_en,
  output logic             gain_20x_en,
  output logic             bandgap_sel,
  output logic             ground_sel,
  output logic             ref_supply_sel,
  output logic             ref_pin_sel,
  output logic             ref_internal_on,
  output logic             ref_pin_connect
);

  // ****************************************************************
  // functions
  // ****************************************************************
  function automatic logic [9:0] sat_code(input logic [11:0] raw);
    logic [9:0] code;
    code = raw[9:0];
    if (raw[11]) begin
      code = AMC_CODE_MIN;
    end else if (raw[10]) begin
      code = AMC_CODE_MAX;
    end
    return code;
  endfunction

  function automatic logic [15:0] align_pair(input logic [9:0] res, input logic left);
    logic [15:0] pair;
    pair = left ? {res, AMC_LEFT_PAD} : {AMC_RIGHT_PAD, res};
    return pair;
  endfunction

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0]  sel_q;
  logic [7:0]  sel_lock_q;
  logic        enable_q;
  logic        start_q;
  logic        free_run_q;
  logic        done_q;
  logic        irq_en_q;
  logic        block_q;
  logic        halted_q;
  logic        core_start_q;
  logic [9:0]  result_q;
  logic [7:0]  rdata_q;
  logic [3:0]  pos_q;
  logic [3:0]  neg_q;
  logic [5:0]  route_q;
  logic [3:0]  ref_q;

  // ****************************************************************
  // decode
  // ****************************************************************
  wire        wr_sel      = reg_wr && (reg_addr == AMC_OFS_INPUT_REF);
  wire        wr_ctl      = reg_wr && (reg_addr == AMC_OFS_CONTROL);
  wire        rd_low      = reg_rd && (reg_addr == AMC_OFS_RESULT_LOW);
  wire        rd_high     = reg_rd && (reg_addr == AMC_OFS_RESULT_HIGH);
  wire        enable_d    = wr_ctl ? reg_wdata[AMC_CTL_ENABLE] : enable_q;
  wire        free_run_d  = wr_ctl ? reg_wdata[AMC_CTL_FREE_RUN] : free_run_q;
  wire        sw_start    = wr_ctl && reg_wdata[AMC_CTL_START] && enable_d && !start_q;
  wire        halt_rise   = cpu_halted && !halted_q;
  wire        sleep_start = halt_rise && sleep_adc_mode && enable_q && !start_q
                            && !free_run_q;
  wire        conv_end    = core_done && start_q && enable_q;
  wire        restart     = conv_end && free_run_q;
  wire        start_d     = enable_d && (sw_start || sleep_start || (start_q && !(conv_end
                            && !free_run_q)));
  wire        done_clr    = (wr_ctl && reg_wdata[AMC_CTL_DONE]) || irq_ack;
  wire        lock_open   = !start_q || core_last_cycle || conv_end;
  wire [15:0] pair        = align_pair(result_q, sel_q[AMC_LEFT_ALIGN]);
  wire [7:0]  ctl_view    = {enable_q, start_q, free_run_q, done_q, irq_en_q, 3'h0};
  wire [1:0]  ref_code    = sel_lock_q[AMC_REF_HI:AMC_REF_LO];

  logic [7:0] rdata_d;
  always_comb begin
    rdata_d = AMC_RDATA_IDLE;
    if (reg_rd) begin
      unique case (reg_addr)
        AMC_OFS_RESULT_LOW:  rdata_d = pair[7:0];
        AMC_OFS_RESULT_HIGH: rdata_d = pair[15:8];
        AMC_OFS_CONTROL:     rdata_d = ctl_view;
        AMC_OFS_INPUT_REF:   rdata_d = sel_q;
        default:             rdata_d = AMC_RDATA_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // channel decoder
  // ****************************************************************
  logic [3:0] dec_pos;
  logic [3:0] dec_neg;
  logic       dec_diff;
  logic       dec_gain;
  logic       dec_bg;
  logic       dec_gnd;

  amc_chan_decode u_decode (
    .chan_code  (sel_lock_q[AMC_CHAN_HI:AMC_CHAN_LO]),
    .pos_sel    (dec_pos),
    .neg_sel    (dec_neg),
    .diff_en    (dec_diff),
    .gain_20x   (dec_gain),
    .bandgap_en (dec_bg),
    .ground_en  (dec_gnd)
  );

  // reference decode
  wire [3:0] ref_d = {ref_code == AMC_REF_SUPPLY,
                      ref_code == AMC_REF_PIN,
                      ref_code[1],
                      ref_code != AMC_REF_INT_OPEN};

  // ****************************************************************
  // register writes and selection lock
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sel_q      <= AMC_INPUT_REF_RST;
      sel_lock_q <= AMC_INPUT_REF_RST;
      enable_q   <= 1'b0;
      free_run_q <= 1'b0;
      irq_en_q   <= 1'b0;
      halted_q   <= 1'b0;
    end else begin
      if (wr_sel) begin
        sel_q <= reg_wdata;
      end
      if (lock_open) begin
        sel_lock_q <= sel_q;
      end
      enable_q   <= enable_d;
      free_run_q <= free_run_d;
      if (wr_ctl) begin
        irq_en_q <= reg_wdata[AMC_CTL_IRQ_EN];
      end
      halted_q <= cpu_halted;
    end
  end

  // ****************************************************************
  // conversion, flag and result
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      start_q      <= 1'b0;
      core_start_q <= 1'b0;
      done_q       <= 1'b0;
      block_q      <= 1'b0;
      result_q     <= AMC_RESULT_RST;
    end else begin
      start_q      <= start_d;
      core_start_q <= sw_start || sleep_start || (restart && enable_d);
      done_q       <= conv_end || (done_q && !done_clr);
      block_q      <= rd_low || (block_q && !rd_high);
      if (conv_end && !block_q) begin
        result_q <= sat_code(core_raw);
      end
    end
  end

  // ****************************************************************
  // registered outputs
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= AMC_RDATA_IDLE;
      pos_q   <= AMC_IN_NONE;
      neg_q   <= AMC_IN_NONE;
      route_q <= 6'h00;
      ref_q   <= 4'h0;
    end else begin
      rdata_q <= rdata_d;
      pos_q   <= dec_pos;
      neg_q   <= dec_neg;
      route_q <= {dec_diff, dec_gain, dec_bg, dec_gnd, 2'h0};
      ref_q   <= ref_d;
    end
  end

  assign reg_rdata       = rdata_q;
  assign core_enable     = enable_q;
  assign core_start      = core_start_q;
  assign conv_irq        = done_q && irq_en_q && global_irq_enable;
  assign wake_request    = conv_irq;
  assign mux_pos_sel     = pos_q;
  assign mux_neg_sel     = neg_q;
  assign mux_diff_en     = route_q[5];
  assign gain_20x_en     = route_q[4];
  assign bandgap_sel     = route_q[3];
  assign ground_sel      = route_q[2];
  assign ref_supply_sel  = ref_q[3];
  assign ref_pin_sel     = ref_q[2];
  assign ref_internal_on = ref_q[1];
  assign ref_pin_connect = ref_q[0];

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_low_read_left;
    rd_low && sel_q[AMC_LEFT_ALIGN] && !wr_sel;
  endsequence

  sequence s_prepared_halt;
    halt_rise && sleep_adc_mode && enable_q && !start_q && !free_run_q && !reg_wr;
  endsequence

  a_sleep_start_go: assert property (s_prepared_halt |=> core_start && start_q)
    else $error("sleep halt did not start a conversion");
  a_no_start_free: assert property (halt_rise && free_run_q && !start_q && !reg_wr
                                    |=> !core_start)
    else $error("halt started a conversion in free-running mode");
  a_wake_on_irq: assert property ($rose(done_q) && irq_en_q && global_irq_enable
                                  |-> wake_request)
    else $error("completion did not wake the processor");
  a_sat_zero: assert property (conv_end && !block_q && core_raw[11]
                               |=> result_q == AMC_CODE_MIN)
    else $error("negative difference not clamped to zero");
  a_sat_full: assert property (conv_end && !block_q && !core_raw[11] && core_raw[10]
                               |=> result_q == AMC_CODE_MAX)
    else $error("full-scale difference not clamped to top code");
  a_code_pass: assert property (conv_end && !block_q && core_raw[11:10] == 2'h0
                                |=> result_q == $past(core_raw[9:0]))
    else $error("in-range result not stored unchanged");
  a_lock_hold: assert property (start_q && !core_last_cycle && !core_done
                                |=> $stable(sel_lock_q))
    else $error("selection changed during a conversion");
  a_idle_follow: assert property (!start_q |=> sel_lock_q == $past(sel_q))
    else $error("selection did not follow register while idle");
  a_block_result: assert property (block_q && !rd_high ##1 conv_end
                                   |=> $stable(result_q) && done_q)
    else $error("blocked result updated or flag not set");
  a_align_now: assert property (s_low_read_left
                                |=> reg_rdata == {$past(result_q[1:0]), AMC_LEFT_PAD})
    else $error("left-aligned low byte wrong");
  a_ref_decode: assert property (1'b1 |=> ref_internal_on == $past(ref_code[1])
                                 && ref_pin_sel == ($past(ref_code) == AMC_REF_PIN))
    else $error("reference decode wrong");
  a_diff_route: assert property (sel_lock_q[AMC_CHAN_HI:AMC_CHAN_LO] <= AMC_CH_LAST_SINGLE
                                 |=> !mux_diff_en && !gain_20x_en)
    else $error("single-ended code routed through gain stage");
  a_bandgap_route: assert property (sel_lock_q[AMC_CHAN_HI:AMC_CHAN_LO] == AMC_CH_BANDGAP
                                    |=> bandgap_sel && !ground_sel && !mux_diff_en)
    else $error("bandgap code not decoded");

endmodule

`default_nettype wire

// ==== pkg/amc_pkg.sv ====
// constants for the converter input, reference and result control block
package amc_pkg;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [7:0] AMC_OFS_RESULT_LOW  = 8'h04;
  localparam logic [7:0] AMC_OFS_RESULT_HIGH = 8'h05;
  localparam logic [7:0] AMC_OFS_CONTROL     = 8'h06;
  localparam logic [7:0] AMC_OFS_INPUT_REF   = 8'h07;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] AMC_INPUT_REF_RST = 8'h00;
  localparam logic [9:0] AMC_RESULT_RST    = 10'h000;
  localparam logic [7:0] AMC_RDATA_IDLE    = 8'h00;

  // ****************************************************************
  // input_reference_select fields
  // ****************************************************************
  localparam int AMC_REF_HI      = 7;
  localparam int AMC_REF_LO      = 6;
  localparam int AMC_LEFT_ALIGN  = 5;
  localparam int AMC_CHAN_HI     = 4;
  localparam int AMC_CHAN_LO     = 0;

  // ****************************************************************
  // control fields
  // ****************************************************************
  localparam int AMC_CTL_ENABLE    = 7;
  localparam int AMC_CTL_START     = 6;
  localparam int AMC_CTL_FREE_RUN  = 5;
  localparam int AMC_CTL_DONE      = 4;
  localparam int AMC_CTL_IRQ_EN    = 3;

  // ****************************************************************
  // reference select codes
  // ****************************************************************
  localparam logic [1:0] AMC_REF_SUPPLY   = 2'h0;
  localparam logic [1:0] AMC_REF_PIN      = 2'h1;
  localparam logic [1:0] AMC_REF_INT_OPEN = 2'h2;
  localparam logic [1:0] AMC_REF_INT_CAP  = 2'h3;

  // ****************************************************************
  // channel codes and result limits
  // ****************************************************************
  localparam logic [4:0] AMC_CH_LAST_SINGLE = 5'h0a;
  localparam logic [4:0] AMC_CH_BANDGAP     = 5'h1e;
  localparam logic [4:0] AMC_CH_GROUND      = 5'h1f;
  localparam logic [3:0] AMC_IN_NONE        = 4'hf;
  localparam logic [9:0] AMC_CODE_MIN       = 10'h000;
  localparam logic [9:0] AMC_CODE_MAX       = 10'h3ff;
  localparam logic [5:0] AMC_LEFT_PAD       = 6'h00;
  localparam logic [5:0] AMC_RIGHT_PAD      = 6'h00;

endpackage

// ==== hw/amc_chan_decode.sv ====
// channel and gain decoder for the analog multiplexer
`timescale 1ns/10ps
`default_nettype none

module amc_chan_decode
  import amc_pkg::*;
(
  input  wire logic [4:0] chan_code,
  output logic      [3:0] pos_sel,
  output logic      [3:0] neg_sel,
  output logic            diff_en,
  output logic            gain_20x,
  output logic            bandgap_en,
  output logic            ground_en
);

  // ****************************************************************
  // decode table
  // ****************************************************************
  always_comb begin
    pos_sel    = AMC_IN_NONE;
    neg_sel    = AMC_IN_NONE;
    diff_en    = 1'b1;
    gain_20x   = 1'b0;
    bandgap_en = 1'b0;
    ground_en  = 1'b0;
    unique case (chan_code)
      5'h0b: begin pos_sel = 4'h0; neg_sel = 4'h1; gain_20x = 1'b1; end
      5'h0c: begin pos_sel = 4'h0; neg_sel = 4'h1; end
      5'h0d: begin pos_sel = 4'h1; neg_sel = 4'h1; gain_20x = 1'b1; end
      5'h0e: begin pos_sel = 4'h2; neg_sel = 4'h1; gain_20x = 1'b1; end
      5'h0f: begin pos_sel = 4'h2; neg_sel = 4'h1; end
      5'h10: begin pos_sel = 4'h2; neg_sel = 4'h3; end
      5'h11: begin pos_sel = 4'h3; neg_sel = 4'h3; gain_20x = 1'b1; end
      5'h12: begin pos_sel = 4'h4; neg_sel = 4'h3; gain_20x = 1'b1; end
      5'h13: begin pos_sel = 4'h4; neg_sel = 4'h3; end
      5'h14: begin pos_sel = 4'h4; neg_sel = 4'h5; gain_20x = 1'b1; end
      5'h15: begin pos_sel = 4'h4; neg_sel = 4'h5; end
      5'h16: begin pos_sel = 4'h5; neg_sel = 4'h5; gain_20x = 1'b1; end
      5'h17: begin pos_sel = 4'h6; neg_sel = 4'h5; gain_20x = 1'b1; end
      5'h18: begin pos_sel = 4'h6; neg_sel = 4'h5; end
      5'h19: begin pos_sel = 4'h8; neg_sel = 4'h9; gain_20x = 1'b1; end
      5'h1a: begin pos_sel = 4'h8; neg_sel = 4'h9; end
      5'h1b: begin pos_sel = 4'h9; neg_sel = 4'h9; gain_20x = 1'b1; end
      5'h1c: begin pos_sel = 4'ha; neg_sel = 4'h9; gain_20x = 1'b1; end
      5'h1d: begin pos_sel = 4'ha; neg_sel = 4'h9; end
      5'h1e: begin diff_en = 1'b0; bandgap_en = 1'b1; end
      5'h1f: begin diff_en = 1'b0; ground_en = 1'b1; end
      default: begin
        // single-ended, gain stage bypassed
        diff_en = 1'b0;
        pos_sel = chan_code[3:0];
      end
    endcase
  end

endmodule

`default_nettype wire

// ==== dv/amc_core_model.sv ====
// converter core stand-in with a timed done pulse
`timescale 1ns/10ps
`default_nettype none
module amc_core_model (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        core_enable,
  input  wire logic        core_start,
  input  wire logic [4:0]  conv_len,
  input  wire logic [11:0] raw_in,
  output logic             core_done,
  output logic             core_last_cycle,
  output logic      [11:0] core_raw
);
  // ********************
  // conversion timer
  // ********************
  logic [4:0]  cnt_q;
  logic [11:0] raw_q;
  assign core_last_cycle = (cnt_q == 5'h01);
  // raw code only meaningful beside done
  assign core_raw = core_done ? raw_q : ~raw_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q     <= 5'h00;
      raw_q     <= 12'h000;
      core_done <= 1'b0;
    end else begin
      core_done <= core_enable && (cnt_q == 5'h01);
      if (!core_enable) begin
        cnt_q <= 5'h00;
      end else if (core_start) begin
        cnt_q <= conv_len;
        raw_q <= raw_in;
      end else if (cnt_q != 5'h00) begin
        cnt_q <= cnt_q - 5'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
// self-checking bench for the converter control block
`timescale 1ns/10ps
`default_nettype none
module tb;
  import amc_pkg::*;
  // ********************
  // signals and instances
  // ********************
  logic        clk_sys, rst_n, reg_wr, reg_rd, global_irq_enable, sleep_adc_mode;
  logic        cpu_halted, irq_ack, conv_irq, wake_request, core_enable, core_start;
  logic        core_done, core_last_cycle, mux_diff_en, gain_20x_en, bandgap_sel;
  logic        ground_sel, ref_supply_sel, ref_pin_sel, ref_internal_on, ref_pin_connect;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [11:0] core_raw, raw_in;
  logic [3:0]  mux_pos_sel, mux_neg_sel;
  logic [4:0]  conv_len;
  int          error_cnt, checked;
  localparam logic [151:0] PAIRS = 152'ha9a99989896565554545434333232121110101;
  localparam logic [31:0]  GAINS = 32'h1ad66800;
  amc_ctrl dut (
    .clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .global_irq_enable, .sleep_adc_mode, .cpu_halted, .irq_ack, .conv_irq, .wake_request,
    .core_enable, .core_start, .core_done, .core_last_cycle, .core_raw, .mux_pos_sel,
    .mux_neg_sel, .mux_diff_en, .gain_20x_en, .bandgap_sel, .ground_sel, .ref_supply_sel,
    .ref_pin_sel, .ref_internal_on, .ref_pin_connect
  );
  amc_core_model core (
    .clk_sys, .rst_n, .core_enable, .core_start, .conv_len, .raw_in, .core_done,
    .core_last_cycle, .core_raw
  );
  // ********************
  // bus and compare tasks
  // ********************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input string m);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1 chk(reg_rdata, e, m);
  endtask
  task automatic res(input logic [9:0] e);
    rdchk(AMC_OFS_RESULT_LOW, e[7:0], "result low");
    rdchk(AMC_OFS_RESULT_HIGH, {6'h00, e[9:8]}, "result high");
  endtask
  task automatic go(input logic [11:0] raw, input logic [4:0] len);
    @(posedge clk_sys);
    raw_in   <= raw;
    conv_len <= len;
    wr(AMC_OFS_CONTROL, 8'hc8);  // enabled, single mode, irq on
  endtask
  task automatic wait_done();
    for (int n = 0; n < 64; n++) begin
      @(posedge clk_sys);
      #1;
      if (core_done === 1'b1) begin
        @(posedge clk_sys);
        #1;
        return;
      end
    end
    chk(8'h00, 8'h01, "no completion");
    test_done();
  endtask
  task automatic watch(input int n, output logic s);
    s = 1'b0;
    repeat (n) begin
      @(posedge clk_sys);
      #1;
      s = s | core_start;
    end
  endtask
  // ********************
  // scenarios
  // ********************
  task automatic t_reset();
    rdchk(AMC_OFS_INPUT_REF, AMC_INPUT_REF_RST, "sel reset");
    rdchk(AMC_OFS_CONTROL, 8'h00, "ctl reset");
    chk({3'h0, ref_supply_sel, mux_pos_sel}, 8'h10, "reset route");
    wr(8'h03, 8'hff);
    rdchk(8'h03, 8'h00, "unmapped");
    wr(AMC_OFS_INPUT_REF, 8'h5a);
    rdchk(AMC_OFS_INPUT_REF, 8'h5a, "sel rw");
  endtask
  task automatic t_decode();
    logic [7:0] e, f;
    for (int c = 0; c < 32; c++) begin
      wr(AMC_OFS_INPUT_REF, 8'(c));
      repeat (3) @(posedge clk_sys);
      #1;
      if (c <= 10) e = {c[3:0], AMC_IN_NONE};
      else if (c >= 30) e = {AMC_IN_NONE, AMC_IN_NONE};
      else e = PAIRS[(c-11)*8 +: 8];
      f = {4'h0, c > 10 && c < 30, GAINS[c], c == 30, c == 31};
      chk({mux_pos_sel, mux_neg_sel}, e, "pair");
      chk({4'h0, mux_diff_en, gain_20x_en, bandgap_sel, ground_sel}, f, "gain");
    end
    for (int r = 0; r < 4; r++) begin
      wr(AMC_OFS_INPUT_REF, {r[1:0], 6'h00});  // all four reference codes, pin reference included
      repeat (3) @(posedge clk_sys);
      #1;
      e = {4'h0, r == 0, r == 1, r > 1, r != 2};
      chk({4'h0, ref_supply_sel, ref_pin_sel, ref_internal_on, ref_pin_connect}, e, "ref");
    end
  endtask
  task automatic t_format();
    wr(AMC_OFS_INPUT_REF, 8'heb);
    go(12'h100, 5'd1);  // first result after channel change discarded
    wait_done();
    go(12'h320, 5'd6);
    wait_done();
    rdchk(AMC_OFS_RESULT_LOW, 8'h00, "left low");
    rdchk(AMC_OFS_RESULT_HIGH, 8'hc8, "left high");
    wr(AMC_OFS_INPUT_REF, 8'hcb);
    rdchk(AMC_OFS_RESULT_LOW, 8'h20, "right low");
    rdchk(AMC_OFS_RESULT_HIGH, 8'h03, "right high");
    chk({6'h0, conv_irq, wake_request}, 8'h03, "irq");
    rdchk(AMC_OFS_CONTROL, 8'h98, "done flag");
    wr(AMC_OFS_CONTROL, 8'h98);
    #1 chk({7'h0, conv_irq}, 8'h00, "irq cleared");
  endtask
  task automatic t_clamp();
    wr(AMC_OFS_INPUT_REF, 8'h0b);
    go(12'hffb, 5'd1);
    wait_done();
    res(10'h000);
    go(12'h500, 5'd2);
    wait_done();
    res(10'h3ff);
    wr(AMC_OFS_INPUT_REF, 8'h03);
    go(12'h3ff, 5'd2);
    wait_done();
    res(AMC_CODE_MAX);
    go(12'h000, 5'd2);
    wait_done();
    res(AMC_CODE_MIN);
  endtask
  task automatic t_lock();
    wr(AMC_OFS_INPUT_REF, 8'h02);
    go(12'h010, 5'd12);
    wr(AMC_OFS_INPUT_REF, 8'h07);
    repeat (3) @(posedge clk_sys);
    #1 chk({4'h0, mux_pos_sel}, 8'h02, "sel locked");
    wait_done();
    @(posedge clk_sys);
    #1 chk({4'h0, mux_pos_sel}, 8'h07, "sel released");
  endtask
  task automatic t_block();
    go(12'h155, 5'd3);
    wait_done();
    rdchk(AMC_OFS_RESULT_LOW, 8'h55, "low first");
    wr(AMC_OFS_CONTROL, 8'h98);
    go(12'h2aa, 5'd3);
    wait_done();
    chk({7'h0, conv_irq}, 8'h01, "irq on lost result");
    rdchk(AMC_OFS_RESULT_HIGH, 8'h01, "old high kept");
    go(12'h0aa, 5'd3);
    wait_done();
    res(10'h0aa);
  endtask
  task automatic t_sleep();
    logic s;
    wr(AMC_OFS_CONTROL, 8'hb8);
    sleep_adc_mode <= 1'b1;
    cpu_halted     <= 1'b1;
    raw_in         <= 12'h123;
    conv_len       <= 5'd8;
    watch(6, s);
    chk({7'h0, s}, 8'h00, "free run halt");
    cpu_halted <= 1'b0;
    wr(AMC_OFS_CONTROL, 8'h88);  // prepared for noise reduction
    cpu_halted <= 1'b1;
    watch(4, s);
    chk({7'h0, s}, 8'h01, "halt start");
    wait_done();
    chk({6'h0, conv_irq, wake_request}, 8'h03, "wake");
    @(posedge clk_sys);
    global_irq_enable <= 1'b0;
    #1 chk({7'h0, conv_irq}, 8'h00, "global off");
    @(posedge clk_sys);
    global_irq_enable <= 1'b1;
    irq_ack           <= 1'b1;
    @(posedge clk_sys);
    irq_ack        <= 1'b0;
    sleep_adc_mode <= 1'b0;
    cpu_halted     <= 1'b0;
    #1 chk({7'h0, conv_irq}, 8'h00, "ack clears");
    res(10'h123);
  endtask
  task automatic t_free();
    raw_in   <= 12'h0c3;
    conv_len <= 5'd20;
    wr(AMC_OFS_CONTROL, 8'he8);  // free running start
    wait_done();
    wait_done();  // second result needs the automatic restart
    rdchk(AMC_OFS_CONTROL, 8'hf8, "free run busy");
    wr(AMC_OFS_CONTROL, 8'h18);
    rdchk(AMC_OFS_CONTROL, 8'h08, "disable ends run");
    chk({7'h0, core_enable}, 8'h00, "core off");
    res(10'h0c3);
  endtask
  // ********************
  // clock and main sequence
  // ********************
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial begin
    {rst_n, reg_wr, reg_rd, sleep_adc_mode, cpu_halted, irq_ack} = 6'h00;
    {reg_addr, reg_wdata, raw_in, conv_len} = 33'h0;
    global_irq_enable = 1'b1;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_decode();
    t_format();
    t_clamp();
    t_lock();
    t_block();
    t_sleep();
    t_free();
    test_done();
  end
endmodule
`default_nettype wire
